// File: rtl/glyph_scroll_pkg.sv
// Behaviour
// - no text block shown, cursor is bar only
// - block shape: block on text, bar on graphics
// - cursor pointer steps by address; software reloads
// - layer window split into two fetch blocks
// - blocks fetch from newly written start addresses
// - start change never clears display memory
// - three-bit pixel offset shifts text blocks only
// - text rows by character, graphics by pixel line
// - one pixel offset shared by all text blocks
// - nonzero offset without extra byte blanks last column
// - rom glyphs: 192 codes, five by seven font
// - at most 64 ram glyph codes when mixed
// - ram glyph height 8 or 16 by config bit
// - glyph ram base anywhere when rom selected
// - glyph ram in use forces one bit per pixel
// - fetch address is base plus code plus row
// - short font: code at 10..3, row 2..0
// - tall font: code at 11..4, row 3..0
// - display on bit, cursor and block fields
// - text blocks wrap horizontally per character
`default_nettype none
package glyph_scroll_pkg;
	localparam logic [5:0] idx_system_configuration = 6'h00;
	localparam logic [5:0] idx_bytes_per_row_count  = 6'h03;
	localparam logic [5:0] idx_line_pitch_low       = 6'h06;
	localparam logic [5:0] idx_line_pitch_high      = 6'h07;
	localparam logic [5:0] idx_display_on_control   = 6'h09;
	localparam logic [5:0] idx_display_attributes   = 6'h0a;
	localparam logic [5:0] idx_block_one_start_low  = 6'h0b;
	localparam logic [5:0] idx_block_one_start_high = 6'h0c;
	localparam logic [5:0] idx_block_two_start_low  = 6'h0e;
	localparam logic [5:0] idx_block_two_start_high = 6'h0f;
	localparam logic [5:0] idx_glyph_ram_base_low   = 6'h19;
	localparam logic [5:0] idx_glyph_ram_base_high  = 6'h1a;
	localparam logic [5:0] idx_pixel_scroll_offset  = 6'h1b;
	localparam logic [5:0] idx_cursor_pointer_low   = 6'h1c;
	localparam logic [5:0] idx_cursor_pointer_high  = 6'h1d;
	localparam logic [5:0] idx_display_mode         = 6'h20;
	localparam logic [5:0] idx_block_status         = 6'h21;
	localparam int cfg_rom_off_bit    = 0;
	localparam int cfg_tall_font_bit  = 2;
	localparam int disp_on_bit        = 0;
	localparam int mode_shape_bit     = 2;
	localparam int attr_block_one_lsb = 2;
	localparam int attr_block_two_lsb = 4;
	localparam logic [7:0] reg_reset_value = 8'h00;
	localparam logic [1:0] field_off = 2'h0;
	localparam logic [1:0] depth_one_bpp = 2'h0;
	localparam logic [7:0] ram_codes_low_first  = 8'h80;
	localparam logic [7:0] ram_codes_low_last   = 8'h9f;
	localparam logic [7:0] ram_codes_high_first = 8'he0;
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [2:0] hsize_word    = 3'h2;
	typedef enum logic [1:0]
	{
		scan_idle = 2'b00,
		scan_block_one = 2'b01,
		scan_block_two = 2'b10
	} scan_state_type;
endpackage
`default_nettype wire

// File: rtl/glyph_scroll.sv
`default_nettype none
module glyph_scroll
	import glyph_scroll_pkg::*;
#(
	parameter int addr_width = 16
)
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic                  frame_start,
	input  wire logic                  line_next,
	input  wire logic                  row_last,
	input  wire logic                  byte_next,
	input  wire logic                  block_switch,
	input  wire logic                  memory_access,
	input  wire logic [7:0]            char_code,
	input  wire logic [3:0]            glyph_row,
	output logic      [addr_width-1:0] display_addr,
	output logic      [addr_width-1:0] glyph_addr,
	output logic                       glyph_from_rom,
	output logic      [2:0]            pixel_shift,
	output logic                       blank_column,
	output logic                       cursor_here,
	output logic                       cursor_block,
	output logic                       display_enable,
	output logic      [1:0]            depth_effective
);
	if (addr_width != 16)
	begin
		$error("glyph_scroll: addr_width must be 16");
	end
	logic [7:0]  system_configuration;
	logic [7:0]  bytes_per_row_count;
	logic [15:0] line_address_pitch;
	logic [7:0]  display_on_control;
	logic [7:0]  display_attributes;
	logic [15:0] block_one_start;
	logic [15:0] block_two_start;
	logic [15:0] glyph_ram_base;
	logic [7:0]  pixel_scroll_offset;
	logic [15:0] cursor_pointer;
	logic [7:0]  display_mode;
	logic        wr_pending;
	logic [5:0]  wr_index;
	logic        rd_pending;
	logic [5:0]  rd_index;
	logic        accept;
	logic        wr_now;
	logic [7:0]  wbyte;
	scan_state_type scan_state;
	scan_state_type next_scan_state;
	logic [15:0] line_one;
	logic [15:0] line_two;
	logic [15:0] column;
	logic [15:0] next_column;
	logic        text_block;
	logic        block_one_on;
	logic        block_two_on;
	logic        cursor_on;
	logic        ram_glyph;
	logic [15:0] cur_line;
	logic [15:0] glyph_sum;

	function automatic logic field_on(input logic [1:0] f);
		field_on = (f != field_off);
	endfunction

	function automatic logic [7:0] pick(input logic [5:0] idx,
		input logic [5:0] want, input logic [7:0] val);
		pick = (idx == want) ? val : 8'h00;
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign accept = hsel && hready && htrans == htrans_nonseq
		&& hsize == hsize_word && haddr[1:0] == 2'h0;
	assign wr_now = wr_pending;
	assign wbyte = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pending <= 1'b0;
			rd_pending <= 1'b0;
			wr_index <= 6'h00;
			rd_index <= 6'h00;
		end
		else if (hready)
		begin
			wr_pending <= accept && hwrite && haddr[31:8] == 24'h000000;
			rd_pending <= accept && !hwrite && haddr[31:8] == 24'h000000;
			wr_index <= haddr[7:2];
			rd_index <= haddr[7:2];
		end
	end

	always_comb
	begin
		hrdata = 32'h00000000;
		if (rd_pending)
		begin
			hrdata[7:0] =
				pick(rd_index, idx_system_configuration, system_configuration)
				| pick(rd_index, idx_bytes_per_row_count, bytes_per_row_count)
				| pick(rd_index, idx_line_pitch_low, line_address_pitch[7:0])
				| pick(rd_index, idx_line_pitch_high, line_address_pitch[15:8])
				| pick(rd_index, idx_display_on_control, display_on_control)
				| pick(rd_index, idx_display_attributes, display_attributes)
				| pick(rd_index, idx_block_one_start_low, block_one_start[7:0])
				| pick(rd_index, idx_block_one_start_high, block_one_start[15:8])
				| pick(rd_index, idx_block_two_start_low, block_two_start[7:0])
				| pick(rd_index, idx_block_two_start_high, block_two_start[15:8])
				| pick(rd_index, idx_glyph_ram_base_low, glyph_ram_base[7:0])
				| pick(rd_index, idx_glyph_ram_base_high, glyph_ram_base[15:8])
				| pick(rd_index, idx_pixel_scroll_offset, pixel_scroll_offset)
				| pick(rd_index, idx_cursor_pointer_low, cursor_pointer[7:0])
				| pick(rd_index, idx_cursor_pointer_high, cursor_pointer[15:8])
				| pick(rd_index, idx_display_mode, display_mode)
				| pick(rd_index, idx_block_status,
					{4'h0, cursor_block, cursor_on, ram_glyph, text_block});
		end
	end
	// configuration registers; start changes only move the fetch pointer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			system_configuration <= reg_reset_value;
			bytes_per_row_count <= reg_reset_value;
			line_address_pitch <= {reg_reset_value, reg_reset_value};
			display_on_control <= reg_reset_value;
			display_attributes <= reg_reset_value;
			block_one_start <= {reg_reset_value, reg_reset_value};
			block_two_start <= {reg_reset_value, reg_reset_value};
			glyph_ram_base <= {reg_reset_value, reg_reset_value};
			pixel_scroll_offset <= reg_reset_value;
			display_mode <= reg_reset_value;
		end
		else if (wr_now)
		begin
			case (wr_index)
				idx_system_configuration: system_configuration <= wbyte;
				idx_bytes_per_row_count: bytes_per_row_count <= wbyte;
				idx_line_pitch_low: line_address_pitch[7:0] <= wbyte;
				idx_line_pitch_high: line_address_pitch[15:8] <= wbyte;
				idx_display_on_control: display_on_control <= wbyte;
				idx_display_attributes: display_attributes <= wbyte;
				idx_block_one_start_low: block_one_start[7:0] <= wbyte;
				idx_block_one_start_high: block_one_start[15:8] <= wbyte;
				idx_block_two_start_low: block_two_start[7:0] <= wbyte;
				idx_block_two_start_high: block_two_start[15:8] <= wbyte;
				idx_glyph_ram_base_low: glyph_ram_base[7:0] <= wbyte;
				idx_glyph_ram_base_high: glyph_ram_base[15:8] <= wbyte;
				idx_pixel_scroll_offset: pixel_scroll_offset <= wbyte;
				idx_display_mode: display_mode <= wbyte;
				default: ;
			endcase
		end
	end
	// pointer steps one address per access; a software write wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cursor_pointer <= {reg_reset_value, reg_reset_value};
		else if (wr_now && wr_index == idx_cursor_pointer_low)
			cursor_pointer[7:0] <= wbyte;
		else if (wr_now && wr_index == idx_cursor_pointer_high)
			cursor_pointer[15:8] <= wbyte;
		else if (memory_access)
			cursor_pointer <= cursor_pointer + 16'h0001;
	end
	// attribute fields
	assign display_enable = display_on_control[disp_on_bit];
	assign cursor_on = field_on(display_attributes[1:0]);
	assign block_one_on = field_on(display_attributes[attr_block_one_lsb +: 2]);
	assign block_two_on = field_on(display_attributes[attr_block_two_lsb +: 2]);
	// block one is the text block of the layer, block two graphics
	assign text_block = scan_state == scan_block_one;

	always_comb
	begin
		next_scan_state = scan_state;
		case (scan_state)
			scan_idle:
				if (frame_start)
					next_scan_state = scan_block_one;
			scan_block_one:
				if (block_switch)
					next_scan_state = scan_block_two;
			scan_block_two:
				if (frame_start)
					next_scan_state = scan_block_one;
			default: next_scan_state = scan_idle;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			scan_state <= scan_idle;
		else
			scan_state <= next_scan_state;
	end
	// each block loads its own start at frame begin
	// text lines step once per character row, graphics every line
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			line_one <= 16'h0000;
			line_two <= 16'h0000;
		end
		else if (frame_start)
		begin
			line_one <= block_one_start;
			line_two <= block_two_start;
		end
		else if (line_next)
		begin
			if (text_block && row_last)
				line_one <= line_one + line_address_pitch;
			if (scan_state == scan_block_two)
				line_two <= line_two + line_address_pitch;
		end
	end
	// column wraps inside the pitch so text blocks scroll round
	always_comb
	begin
		next_column = column;
		if (frame_start || line_next)
			next_column = 16'h0000;
		else if (byte_next)
		begin
			if (column + 16'h0001 >= line_address_pitch)
				next_column = 16'h0000;
			else
				next_column = column + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			column <= 16'h0000;
		else
			column <= next_column;
	end
	assign cur_line = text_block ? line_one : line_two;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			display_addr <= 16'h0000;
		else
			display_addr <= cur_line + column;
	end
	// one shared offset, text only, zero in grayscale
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pixel_shift <= 3'h0;
		else if (text_block && depth_effective == depth_one_bpp)
			pixel_shift <= pixel_scroll_offset[2:0];
		else
			pixel_shift <= 3'h0;
	end
	// last column blank unless software widened the row by one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			blank_column <= 1'b0;
		else
			blank_column <= text_block && pixel_scroll_offset[2:0] != 3'h0
				&& bytes_per_row_count != 8'h00
				&& column[7:0] == bytes_per_row_count - 8'h01;
	end
	// bar only without text, block only over text positions
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cursor_here <= 1'b0;
			cursor_block <= 1'b0;
		end
		else
		begin
			cursor_here <= cursor_on && (cur_line + column) == cursor_pointer;
			cursor_block <= display_mode[mode_shape_bit] && block_one_on
				&& text_block;
		end
	end
	// ram codes 80..9f and e0..ff, 64 in all; rest from rom, all from ram when rom off bit set
	assign ram_glyph = system_configuration[cfg_rom_off_bit]
		|| (char_code >= ram_codes_low_first && char_code <= ram_codes_low_last)
		|| char_code >= ram_codes_high_first;
	// glyph ram in use limits depth to one bit
	assign depth_effective = ram_glyph ? depth_one_bpp : display_mode[1:0];
	// base plus shifted code plus row, carry dropped
	always_comb
	begin
		if (system_configuration[cfg_tall_font_bit])
			glyph_sum = glyph_ram_base + {4'h0, char_code, glyph_row};
		else
			glyph_sum = glyph_ram_base
				+ {5'h00, char_code, glyph_row[2:0]};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			glyph_addr <= 16'h0000;
			glyph_from_rom <= 1'b0;
		end
		else
		begin
			glyph_addr <= glyph_sum;
			glyph_from_rom <= !ram_glyph;
		end
	end

	property p_bar_without_text;
		@(posedge hclk) disable iff (!hresetn)
		!block_one_on |=> !cursor_block;
	endproperty
	a_bar_without_text: assert property (p_bar_without_text)
		else $error("block cursor with no text block");
	property p_bar_on_graphics;
		@(posedge hclk) disable iff (!hresetn)
		(scan_state == scan_block_two) |=> !cursor_block;
	endproperty
	a_bar_on_graphics: assert property (p_bar_on_graphics)
		else $error("block cursor over graphics");
	property p_pointer_step;
		@(posedge hclk) disable iff (!hresetn)
		(memory_access && !wr_now) |=>
			cursor_pointer == $past(cursor_pointer) + 16'h0001;
	endproperty
	a_pointer_step: assert property (p_pointer_step)
		else $error("cursor pointer did not step by one");
	property p_frame_load;
		@(posedge hclk) disable iff (!hresetn)
		frame_start |=> line_one == $past(block_one_start)
			&& line_two == $past(block_two_start);
	endproperty
	a_frame_load: assert property (p_frame_load)
		else $error("block start not loaded");
	property p_shift_text_only;
		@(posedge hclk) disable iff (!hresetn)
		!text_block |=> pixel_shift == 3'h0;
	endproperty
	a_shift_text_only: assert property (p_shift_text_only)
		else $error("pixel shift outside text block");
	property p_text_row_step;
		@(posedge hclk) disable iff (!hresetn)
		(line_next && text_block && !row_last && !frame_start)
			|=> $stable(line_one);
	endproperty
	a_text_row_step: assert property (p_text_row_step)
		else $error("text line moved inside character row");
	property p_one_bpp;
		@(posedge hclk) disable iff (!hresetn)
		ram_glyph |-> depth_effective == depth_one_bpp;
	endproperty
	a_one_bpp: assert property (p_one_bpp)
		else $error("grayscale with glyph ram");
	property p_glyph_short;
		@(posedge hclk) disable iff (!hresetn)
		!system_configuration[cfg_tall_font_bit] |=> glyph_addr ==
			16'($past(glyph_ram_base) + {$past(char_code), 3'h0}
			+ $past(glyph_row[2:0]));
	endproperty
	a_glyph_short: assert property (p_glyph_short)
		else $error("short font glyph address wrong");
	property p_glyph_tall;
		@(posedge hclk) disable iff (!hresetn)
		system_configuration[cfg_tall_font_bit] |=> glyph_addr ==
			16'($past(glyph_ram_base) + {$past(char_code), 4'h0}
			+ $past(glyph_row));
	endproperty
	a_glyph_tall: assert property (p_glyph_tall)
		else $error("tall font glyph address wrong");
endmodule
`default_nettype wire

// File: tb/test_glyph_scroll.sv
`default_nettype none
`define check(a, b) \
	begin \
		comparisons++; \
		if ((a) !== (b)) \
		begin \
			fails++; \
			$display("[ERR] %0t got %h exp %h", $time, a, b); \
		end \
	end
module test_glyph_scroll import glyph_scroll_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, act, got_exp;
	logic [1:0]  htrans, depth_effective;
	logic [2:0]  hsize, pixel_shift;
	logic        frame_start, line_next, row_last, byte_next;
	logic        block_switch, memory_access, glyph_from_rom;
	logic        blank_column, cursor_here, cursor_block, display_enable;
	logic [7:0]  char_code, v, code;
	logic [3:0]  glyph_row, check_sel;
	logic [15:0] display_addr, glyph_addr, base, ga;
	logic [31:0] notes[$];
	int          fails, comparisons, cycles;
	logic [5:0]  regs [11] = '{idx_system_configuration,
		idx_bytes_per_row_count, idx_line_pitch_low, idx_line_pitch_high,
		idx_display_on_control, idx_display_attributes,
		idx_glyph_ram_base_low, idx_glyph_ram_base_high,
		idx_pixel_scroll_offset, idx_cursor_pointer_low,
		idx_cursor_pointer_high};
	logic [7:0]  edge_codes [4] = '{8'h9f, 8'ha0, 8'he0, 8'h7f};
	assign hready = hreadyout;
	glyph_scroll #(.addr_width(16)) u_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .frame_start(frame_start),
		.line_next(line_next), .row_last(row_last), .byte_next(byte_next),
		.block_switch(block_switch), .memory_access(memory_access),
		.char_code(char_code), .glyph_row(glyph_row),
		.display_addr(display_addr), .glyph_addr(glyph_addr),
		.glyph_from_rom(glyph_from_rom), .pixel_shift(pixel_shift),
		.blank_column(blank_column), .cursor_here(cursor_here),
		.cursor_block(cursor_block), .display_enable(display_enable),
		.depth_effective(depth_effective));
	always #5 hclk = ~hclk;
	// selected output for the watcher
	always_comb
	begin
		case (check_sel)
			4'd1: act = hrdata;
			4'd2: act = {16'h0, glyph_addr};
			4'd3: act = {31'h0, glyph_from_rom};
			4'd4: act = {29'h0, pixel_shift};
			4'd5: act = {31'h0, blank_column};
			4'd6: act = {31'h0, cursor_here};
			4'd7: act = {31'h0, cursor_block};
			4'd8: act = {16'h0, display_addr};
			4'd9: act = {30'h0, depth_effective};
			4'd11: act = {30'h0, hresp, hreadyout};
			default: act = {31'h0, display_enable};
		endcase
	end
	// watcher: oldest note against the output that appears
	always @(posedge hclk)
	begin
		if (check_sel != 4'd0)
		begin
			if (notes.size() == 0)
				`check(act, 32'hffff_ffff)
			else
			begin
				got_exp = notes.pop_front();
				`check(act, got_exp)
			end
		end
	end
	task automatic close_out();
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			close_out();
		end
	end
	task automatic bus(input logic w, input logic [5:0] idx,
		input logic [7:0] val, input logic [7:0] ev);
		hsel <= 1'b1;
		htrans <= htrans_nonseq;
		hsize <= hsize_word;
		hwrite <= w;
		haddr <= {24'h0, idx, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, val};
		if (!w)
		begin
			notes.push_back({24'h0, ev});
			check_sel <= 4'd1;
		end
		do @(posedge hclk); while (hreadyout !== 1'b1);
		check_sel <= 4'd0;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] val);
		bus(1'b1, idx, val, 8'h00);
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] ev);
		bus(1'b0, idx, 8'h00, ev);
	endtask
	task automatic wr16(input logic [5:0] idx, input logic [15:0] val);
		wr(idx, val[7:0]);
		wr(idx + 6'h1, val[15:8]);
	endtask
	task automatic expect_out(input logic [3:0] sel, input logic [31:0] ev);
		repeat (3) @(posedge hclk);
		notes.push_back(ev);
		check_sel <= sel;
		@(posedge hclk);
		check_sel <= 4'd0;
		@(posedge hclk);
	endtask
	// order: frame, line, byte, switch, access
	task automatic pulse(input logic [4:0] s);
		{frame_start, line_next, byte_next, block_switch, memory_access} <= s;
		@(posedge hclk);
		{frame_start, line_next, byte_next, block_switch, memory_access} <= 5'h00;
		@(posedge hclk);
	endtask
	function automatic logic is_ram(input logic [7:0] c);
		return (c >= ram_codes_low_first && c <= ram_codes_low_last)
			|| c >= ram_codes_high_first;
	endfunction
	initial
	begin
		hclk = 0;
		hresetn = 0;
		{hsel, hwrite, row_last, frame_start, line_next} = '0;
		{byte_next, block_switch, memory_access} = '0;
		{haddr, hwdata, htrans, hsize, char_code, glyph_row} = '0;
		check_sel = 4'h0;
		void'($urandom(32'ha89e));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (regs[i])
			rd(regs[i], reg_reset_value);
		foreach (regs[i])
		begin
			v = 8'($urandom);
			wr(regs[i], v);
			rd(regs[i], v);
		end
		rd(6'h3f, 8'h00);
		wr(6'h3f, 8'h5a);
		expect_out(4'd11, 32'h1);
		rd(6'h3f, 8'h00);
		// glyph fetch address in both font heights
		for (int i = 0; i < 8; i++)
		begin
			base = (i < 2) ? 16'hfff0 : 16'($urandom);
			code = (i < 4) ? edge_codes[i] : 8'($urandom);
			v = 8'($urandom);
			wr(idx_system_configuration, {5'h0, i[0], 2'h0});
			wr16(idx_glyph_ram_base_low, base);
			char_code <= code;
			glyph_row <= v[3:0];
			if (i[0])
				ga = base + {4'h0, code, 4'h0} + {12'h0, v[3:0]};
			else
				ga = base + {5'h0, code, 3'h0} + {13'h0, v[2:0]};
			expect_out(4'd2, {16'h0, ga});
			expect_out(4'd3, {31'h0, !is_ram(code)});
		end
		wr(idx_display_mode, 8'h01);
		wr(idx_system_configuration, 8'h01);
		char_code <= 8'h41;
		expect_out(4'd3, 32'h0);
		expect_out(4'd9, 32'h0);
		wr(idx_system_configuration, 8'h00);
		expect_out(4'd9, 32'h1);
		char_code <= 8'h85;
		expect_out(4'd9, 32'h0);
		char_code <= 8'h41;
		wr(idx_display_on_control, 8'h01);
		expect_out(4'd10, 32'h1);
		wr(idx_display_on_control, 8'h00);
		expect_out(4'd10, 32'h0);
		// two blocks, line pitch and pixel offset
		wr(idx_display_mode, 8'h00);
		wr16(idx_line_pitch_low, 16'h0010);
		wr(idx_bytes_per_row_count, 8'h04);
		wr(idx_pixel_scroll_offset, 8'h05);
		wr16(idx_block_one_start_low, 16'h1234);
		wr16(idx_block_two_start_low, 16'h2000);
		pulse(5'b10000);
		expect_out(4'd8, 32'h1234);
		expect_out(4'd4, 32'h5);
		expect_out(4'd5, 32'h0);
		repeat (3) pulse(5'b00100);
		expect_out(4'd8, 32'h1237);
		expect_out(4'd5, 32'h1);
		row_last <= 1'b0;
		pulse(5'b01000);
		expect_out(4'd8, 32'h1234);
		row_last <= 1'b1;
		pulse(5'b01000);
		expect_out(4'd8, 32'h1244);
		pulse(5'b00010);
		expect_out(4'd8, 32'h2000);
		expect_out(4'd4, 32'h0);
		row_last <= 1'b0;
		pulse(5'b01000);
		expect_out(4'd8, 32'h2010);
		wr16(idx_block_one_start_low, 16'h1244);
		pulse(5'b10000);
		expect_out(4'd8, 32'h1244);
		wr(idx_display_mode, 8'h01);
		expect_out(4'd4, 32'h0);
		// cursor shape and visibility
		wr(idx_display_mode, 8'h04);
		wr(idx_display_attributes, 8'h15);
		wr16(idx_cursor_pointer_low, 16'h1244);
		expect_out(4'd6, 32'h1);
		expect_out(4'd7, 32'h1);
		pulse(5'b00010);
		wr16(idx_cursor_pointer_low, 16'h2000);
		expect_out(4'd6, 32'h1);
		expect_out(4'd7, 32'h0);
		wr(idx_display_attributes, 8'h11);
		pulse(5'b10000);
		wr16(idx_cursor_pointer_low, 16'h1244);
		expect_out(4'd7, 32'h0);
		wr16(idx_cursor_pointer_low, 16'h12ff);
		expect_out(4'd6, 32'h0);
		pulse(5'b00001);
		rd(idx_cursor_pointer_low, 8'h00);
		rd(idx_cursor_pointer_high, 8'h13);
		// reset in mid-run brings the registers back to zero
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(idx_cursor_pointer_high, reg_reset_value);
		rd(idx_block_one_start_high, reg_reset_value);
		close_out();
	end
endmodule
`default_nettype wire
